// file: pwm_ramp_defs.svh
/*
 * timing constants, register offsets, field positions and script opcodes
 * for the scripted three-channel pwm ramp engine.
 * assumes inclusion by bare name from the top module and the bench.
 */
`ifndef PWM_RAMP_DEFS_SVH
`define PWM_RAMP_DEFS_SVH

// ==========================================================
// clocking
`define CLK_HZ             100000000
`define SLOW_HZ            32768
// tick period in system cycles, rounded down (shortest time)
`define SLOW_TICK_CYC      (`CLK_HZ / `SLOW_HZ)
`define SLOW_DIVIDER_SELECT_FAST      16
`define SLOW_DIVIDER_SELECT_SLOW      512

// ==========================================================
// register offsets (byte addresses)
`define OFS_CTRL           8'h00
`define OFS_WRITE          8'h04
`define OFS_STATUS         8'h08
`define OFS_IRQ            8'h0C
`define OFS_DUTY           8'h10

// ==========================================================
// ctrl register fields
`define CTRL_START_LSB     0
`define CTRL_STOP_LSB      4
`define CTRL_STEPIRQ_LSB   8
`define CTRL_PWM2PIN_BIT   12
// write register fields
`define WR_WORD_LSB        0
`define WR_ADDR_LSB        16
`define WR_CHAN_LSB        24

// ==========================================================
// script word fields
`define SCRIPT_DEPTH       64
`define MAX_BRANCH_ADDR    6'd59
`define OP_ENDCMD          3'h6
`define OP_BRANCH          3'h5
`define OP_TRIGGER         3'h7

`endif

// file: pwm_ramp_pkg.sv
/*
 * shared types of the pwm ramp engine.
 * assumes pwm_ramp_defs.svh for numbers.
 */
package pwm_ramp_pkg;

    // ======================================================
    // engine states, one-hot
    typedef enum logic [4:0]
    {
        ST_IDLE  = 5'h01,
        ST_FETCH = 5'h02,
        ST_LOAD  = 5'h04,
        ST_RAMP  = 5'h08,
        ST_WAIT  = 5'h10
    } eng_state_t;

    // ======================================================
    // host request toward one engine
    typedef struct packed
    {
        logic        wr;      // store word
        logic        start;   // launch script
        logic        stop;    // stop script
        logic [5:0]  addr;    // script file address
        logic [15:0] word;    // script word
    } host_req_t;

endpackage : pwm_ramp_pkg

// file: pwm_ramp_engine.sv
/*
 * three scripted pwm channels behind an axi4-lite slave.
 * assumes one clock aclk at 100 mhz; the 32.768 khz execution tick
 * is derived from it, so requests need no crossing beyond a pulse.
 */
`timescale 1ns/1ns
`default_nettype none
`include "pwm_ramp_defs.svh"

// Notes on behaviour
// - three pwm outputs, independent autonomous engines
// - host commands: store word, start, stop
// - stop waits for running ramp end
// - 16-bit script word with address
// - queue: file output, buffer, active
// - fetch enters slow domain, buffer, active
// - finished active takes buffered, refetch follows
// - queue registers hidden from host
// - stop or end halts; end raises irq
// - fixed 256-count period, programmable duty ramp
// - period counter runs from ramp to end
// - output high when period <= ramp
// - step rate: prescaler 16/512, step counter
// - ramp counter saturates, never wraps
// - all requested steps execute after saturation
// - optional irq after last ramp step
// - pwm use overrides second config pin gpio
// - zero word jumps; zero cycles_per_step loads duty
// - end with reset flag tristates output
// - branch with loop count, no nesting
module pwm_ramp_engine #(
    parameter int CHANNELS = 3,
    parameter int DEPTH    = `SCRIPT_DEPTH
)(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // pwm pins and host interrupt
    output var  logic [2:0]  pwm_out,
    output var  logic [2:0]  pwm_oe,
    output var  logic        cfg2_pwm_sel,
    output var  logic        irq_out
);

    // ======================================================
    // bus slave state
    logic        aw_got_r, aw_got_nxt;        // address held
    logic        w_got_r,  w_got_nxt;         // data held
    logic [7:0]  awa_r,    awa_nxt;
    logic [31:0] wd_r,     wd_nxt;
    logic        bv_r,     bv_nxt;
    logic [1:0]  bresp_r,  bresp_nxt;
    logic        rv_r,     rv_nxt;
    logic [31:0] rd_r,     rd_nxt;
    logic [1:0]  rresp_r,  rresp_nxt;
    logic        awrdy_r;                     // registered readies, so the
    logic        wrdy_r;                      // ports come straight from a
    logic        ardy_r;                      // flip-flop, not an inverter
    logic [2:0]  stepirq_r, stepirq_nxt;      // ramp-end irq option
    logic        pin_sel_r, pin_sel_nxt;      // pwm on config pin
    logic [2:0]  irq_r,    irq_nxt;           // sticky irq causes
    logic        do_wr;                       // write commits now
    logic [2:0]  clr_irq;                     // write-one-to-clear
    pwm_ramp_pkg::host_req_t req [CHANNELS];  // per-channel request
    logic [2:0]  ev_end, ev_step;             // engine events
    logic [2:0]  running;                     // engine busy
    logic [7:0]  duty [CHANNELS];

    assign do_wr   = aw_got_r && w_got_r && !bv_r;
    assign clr_irq = (do_wr && awa_r == `OFS_IRQ) ? wd_r[2:0] : 3'h0;

    // ======================================================
    // bus next state; aw and w accepted in any order
    always_comb
    begin
        aw_got_nxt  = aw_got_r;
        w_got_nxt   = w_got_r;
        awa_nxt     = awa_r;
        wd_nxt      = wd_r;
        bv_nxt      = bv_r;
        bresp_nxt   = bresp_r;
        rv_nxt      = rv_r;
        rd_nxt      = rd_r;
        rresp_nxt   = rresp_r;
        stepirq_nxt = stepirq_r;
        pin_sel_nxt = pin_sel_r;
        // set wins over clear on irq bits
        irq_nxt     = (irq_r & ~clr_irq) | ev_end | ev_step;
        if (s_axi_awvalid && !aw_got_r)
        begin
            aw_got_nxt = 1'b1;
            awa_nxt    = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_r)
        begin
            w_got_nxt = 1'b1;
            wd_nxt    = s_axi_wdata;
        end
        if (do_wr)
        begin
            bv_nxt    = 1'b1;
            bresp_nxt = 2'b00;
            case (awa_r)
                `OFS_CTRL:
                begin
                    stepirq_nxt = wd_r[`CTRL_STEPIRQ_LSB +: 3];
                    pin_sel_nxt = wd_r[`CTRL_PWM2PIN_BIT];
                end
                `OFS_WRITE, `OFS_IRQ: ;
                default: bresp_nxt = 2'b10;  // unmapped: slverr
            endcase
        end
        if (bv_r && s_axi_bready)
        begin
            bv_nxt     = 1'b0;
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
        end
        if (s_axi_arvalid && !rv_r)
        begin
            rv_nxt    = 1'b1;
            rresp_nxt = 2'b00;
            // queue registers are not mapped
            // queue stays hidden
            case (s_axi_araddr)
                `OFS_CTRL:   rd_nxt = {19'h0, pin_sel_r, 1'b0, stepirq_r, 8'h0};
                `OFS_STATUS: rd_nxt = {29'h0, running};
                `OFS_IRQ:    rd_nxt = {29'h0, irq_r};
                `OFS_DUTY:   rd_nxt = {8'h0, duty[2], duty[1], duty[0]};
                default:
                begin
                    rd_nxt    = 32'h0;
                    rresp_nxt = 2'b10;
                end
            endcase
        end
        else if (rv_r && s_axi_rready)
            rv_nxt = 1'b0;
    end

    // bus registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awa_r     <= 8'h0;
            wd_r      <= 32'h0;
            bv_r      <= 1'b0;
            bresp_r   <= 2'h0;
            rv_r      <= 1'b0;
            rd_r      <= 32'h0;
            rresp_r   <= 2'h0;
            stepirq_r <= 3'h0;
            pin_sel_r <= 1'b0;
            irq_r     <= 3'h0;
            irq_out   <= 1'b0;
            // readies stay high through reset
            awrdy_r   <= 1'b1;
            wrdy_r    <= 1'b1;
            ardy_r    <= 1'b1;
        end
        else
        begin
            aw_got_r  <= aw_got_nxt;
            w_got_r   <= w_got_nxt;
            awa_r     <= awa_nxt;
            wd_r      <= wd_nxt;
            bv_r      <= bv_nxt;
            bresp_r   <= bresp_nxt;
            rv_r      <= rv_nxt;
            rd_r      <= rd_nxt;
            rresp_r   <= rresp_nxt;
            stepirq_r <= stepirq_nxt;
            pin_sel_r <= pin_sel_nxt;
            irq_r     <= irq_nxt;
            irq_out   <= |irq_nxt;
            // ready is the inverse of the next held flag
            awrdy_r   <= !aw_got_nxt;
            wrdy_r    <= !w_got_nxt;
            ardy_r    <= !rv_nxt;
        end
    end

    assign s_axi_awready = awrdy_r;
    assign s_axi_wready  = wrdy_r;
    assign s_axi_bvalid  = bv_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = ardy_r;
    assign s_axi_rvalid  = rv_r;
    assign s_axi_rdata   = rd_r;
    assign s_axi_rresp   = rresp_r;
    assign cfg2_pwm_sel  = pin_sel_r;

    // ======================================================
    // slow tick: 32.768 khz from aclk, shared by all engines
    logic [11:0] tick_cnt_r;
    logic        tick_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tick_cnt_r <= 12'h0;
            tick_r     <= 1'b0;
        end
        else
        begin
            tick_r     <= (tick_cnt_r == 12'(`SLOW_TICK_CYC - 1));
            tick_cnt_r <= (tick_cnt_r == 12'(`SLOW_TICK_CYC - 1)) ? 12'h0
                        : tick_cnt_r + 12'h1;
        end
    end

    // ======================================================
    // per-channel engines
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++)
        begin : g_ch
            logic [15:0] file_r [DEPTH];     // script file
            logic [15:0] fout_r;             // file output register
            logic        fout_v_r;
            logic [15:0] buf_r;              // command buffer
            logic        buf_v_r;
            logic [15:0] act_r;              // active command
            logic [5:0]  pc_r;
            logic [5:0]  loop_r;             // branch repeats left
            logic        loop_v_r;
            logic        stop_pend_r;
            logic        per_run_r;
            logic [7:0]  per_r, ramp_r;
            logic [8:0]  pre_r;
            logic [5:0]  stp_r;
            logic [6:0]  steps_r;
            logic        oe_r, pwm_r, end_ev_r, step_ev_r;
            pwm_ramp_pkg::eng_state_t st_r;
            logic [15:0] b_i;

            assign req[gi].wr    = do_wr && awa_r == `OFS_WRITE
                                && wd_r[`WR_CHAN_LSB +: 2] == 2'(gi);
            assign req[gi].start = do_wr && awa_r == `OFS_CTRL
                                && wd_r[`CTRL_START_LSB + gi];
            assign req[gi].stop  = do_wr && awa_r == `OFS_CTRL
                                && wd_r[`CTRL_STOP_LSB + gi];
            assign req[gi].addr  = wd_r[`WR_ADDR_LSB +: 6];
            assign req[gi].word  = wd_r[`WR_WORD_LSB +: 16];
            assign b_i           = buf_r;

            // engine sequencer and timer, one process per channel
            always_ff @(posedge aclk)
            begin
                end_ev_r  <= 1'b0;
                step_ev_r <= 1'b0;
                if (req[gi].wr)
                    file_r[req[gi].addr] <= req[gi].word;
                if (!aresetn)
                begin
                    st_r <= pwm_ramp_pkg::ST_IDLE;
                    fout_v_r <= 1'b0; buf_v_r <= 1'b0; pc_r <= 6'h0;
                    loop_v_r <= 1'b0; stop_pend_r <= 1'b0; per_run_r <= 1'b0;
                    per_r <= 8'h0; ramp_r <= 8'h0; oe_r <= 1'b0; pwm_r <= 1'b0;
                    act_r <= 16'h0; buf_r <= 16'h0; fout_r <= 16'h0;
                    pre_r <= 9'h0; stp_r <= 6'h0; steps_r <= 7'h0; loop_r <= 6'h0;
                end
                else
                begin
                    if (req[gi].stop && st_r != pwm_ramp_pkg::ST_IDLE)
                        stop_pend_r <= 1'b1;
                    if (tick_r && per_run_r)
                        per_r <= per_r + 8'h1;
                    pwm_r <= per_run_r && (per_r <= ramp_r);
                    // fetch into file output, then buffer
                    if (st_r != pwm_ramp_pkg::ST_IDLE && !fout_v_r)
                    begin
                        fout_r   <= file_r[pc_r];
                        fout_v_r <= 1'b1;
                        pc_r     <= pc_r + 6'h1;
                    end
                    else if (fout_v_r && !buf_v_r && tick_r)
                    begin
                        buf_r    <= fout_r;
                        buf_v_r  <= 1'b1;
                        fout_v_r <= 1'b0;
                    end
                    case (st_r)
                        pwm_ramp_pkg::ST_IDLE:
                        if (req[gi].start)
                        begin
                            st_r <= pwm_ramp_pkg::ST_FETCH;
                            pc_r <= 6'h0; fout_v_r <= 1'b0; buf_v_r <= 1'b0;
                            loop_v_r <= 1'b0; stop_pend_r <= 1'b0;
                        end
                        pwm_ramp_pkg::ST_FETCH:
                        if (stop_pend_r || req[gi].stop)
                            st_r <= pwm_ramp_pkg::ST_IDLE;
                        else if (buf_v_r && tick_r)
                        begin
                            act_r   <= b_i;
                            buf_v_r <= 1'b0;
                            st_r    <= pwm_ramp_pkg::ST_LOAD;
                        end
                        pwm_ramp_pkg::ST_LOAD:
                        begin
                            st_r <= pwm_ramp_pkg::ST_FETCH;
                            if (act_r == 16'h0)
                            begin
                                pc_r <= 6'h0; fout_v_r <= 1'b0; buf_v_r <= 1'b0;
                            end
                            else if (!act_r[15] && act_r[13:8] == 6'h0)
                            begin
                                ramp_r <= act_r[7:0];
                                oe_r   <= 1'b1;
                            end
                            else if (!act_r[15])
                            begin
                                per_run_r <= 1'b1;
                                oe_r      <= 1'b1;
                                pre_r <= 9'h0; stp_r <= 6'h0;
                                steps_r <= act_r[6:0];
                                st_r <= (act_r[6:0] == 7'h0) ? pwm_ramp_pkg::ST_FETCH
                                      : pwm_ramp_pkg::ST_RAMP;
                            end
                            else if (act_r[15:13] == `OP_BRANCH)
                            begin
                                // loop count biased, single level
                                // count n gives n-1 repeats: count 1 falls through
                                if (act_r[5:0] <= `MAX_BRANCH_ADDR
                                    && (act_r[12:7] == 6'h0
                                        || (!loop_v_r && act_r[12:7] != 6'h1)
                                        || (loop_v_r && loop_r != 6'h0)))
                                begin
                                    if (act_r[12:7] != 6'h0)
                                    begin
                                        loop_r   <= loop_v_r ? loop_r - 6'h1
                                                  : act_r[12:7] - 6'h2;
                                        loop_v_r <= 1'b1;
                                    end
                                    pc_r <= act_r[5:0];
                                    fout_v_r <= 1'b0; buf_v_r <= 1'b0;
                                end
                                else
                                    loop_v_r <= 1'b0;
                            end
                            else if (act_r[15:12] == {`OP_ENDCMD, 1'b0})
                            begin
                                st_r      <= pwm_ramp_pkg::ST_IDLE;
                                per_run_r <= 1'b0;
                                end_ev_r  <= 1'b1;
                                if (act_r[11])
                                    oe_r <= 1'b0;
                            end
                            else
                                // trigger: waits a fixed sixteen ticks
                                st_r <= pwm_ramp_pkg::ST_WAIT;
                            pre_r <= 9'h0;
                        end
                        pwm_ramp_pkg::ST_RAMP:
                        if (tick_r)
                        begin
                            if (pre_r == (act_r[14] ? 9'(`SLOW_DIVIDER_SELECT_SLOW - 1)
                                                   : 9'(`SLOW_DIVIDER_SELECT_FAST - 1)))
                            begin
                                pre_r <= 9'h0;
                                if (stp_r == act_r[13:8] - 6'h1)
                                begin
                                    stp_r   <= 6'h0;
                                    if (act_r[7] && ramp_r != 8'h00)
                                        ramp_r <= ramp_r - 8'h1;
                                    else if (!act_r[7] && ramp_r != 8'hFF)
                                        ramp_r <= ramp_r + 8'h1;
                                    steps_r <= steps_r - 7'h1;
                                    if (steps_r == 7'h1)
                                    begin
                                        step_ev_r <= stepirq_r[gi];
                                        st_r <= pwm_ramp_pkg::ST_FETCH;
                                    end
                                end
                                else
                                    stp_r <= stp_r + 6'h1;
                            end
                            else
                                pre_r <= pre_r + 9'h1;
                        end
                        pwm_ramp_pkg::ST_WAIT:
                        if (tick_r)
                        begin
                            pre_r <= pre_r + 9'h1;
                            if (pre_r == 9'(`SLOW_DIVIDER_SELECT_FAST - 1))
                                st_r <= pwm_ramp_pkg::ST_FETCH;
                        end
                        default: st_r <= pwm_ramp_pkg::ST_IDLE;
                    endcase
                end
            end

            assign pwm_out[gi]  = pwm_r;
            assign pwm_oe[gi]   = oe_r;
            assign ev_end[gi]   = end_ev_r;
            assign ev_step[gi]  = step_ev_r;
            assign running[gi]  = (st_r != pwm_ramp_pkg::ST_IDLE);
            assign duty[gi]     = ramp_r;
        end
    endgenerate

endmodule : pwm_ramp_engine
`default_nettype wire

// file: pwm_ramp_engine_sva.sv
/* checker: bus and pin relations at the pwm ramp engine ports.
   assumes a bind onto pwm_ramp_engine, one clock, sync reset. */
`timescale 1ns/1ns
`default_nettype none
module pwm_ramp_engine_sva (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic cfg2_pwm_sel,
    input wire logic irq_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==================================
    // write steps: taken, awready drops, answer
    sequence s_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence s_answer;
        !s_axi_awready ##1 s_axi_bvalid;
    endsequence
    // ==================================
    // answers and holds
    a_write_answer: assert property (s_taken |=> s_answer) else $error("late write");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    a_aw_held: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late read");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid stuck");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
    // cfg2 changes and irq drops need a write behind them
    a_cfg2_cause: assert property ($changed(cfg2_pwm_sel) |-> !$past(s_axi_awready))
        else $error("cfg2 moved alone");
    a_irq_clear: assert property ($fell(irq_out) |-> !$past(s_axi_awready))
        else $error("irq dropped alone");
    a_reset_quiet: assert property ($rose(aresetn) |-> !irq_out && !s_axi_bvalid)
        else $error("not quiet after reset");
endmodule : pwm_ramp_engine_sva
`default_nettype wire

// file: axi_host_model.sv
/* host model: axi4-lite master storing script words, starting runs.
   assumes one clock aclk; waits on the slave however long it takes. */
`timescale 1ns/1ns
`default_nettype none
module axi_host_model (
    input  wire logic        aclk,
    // write side
    output logic [7:0]  s_axi_awaddr,
    output logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0]  s_axi_wstrb,
    output logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic        s_axi_bvalid,
    input  wire logic [1:0]  s_axi_bresp,
    output logic        s_axi_bready,
    // read side
    output logic [7:0]  s_axi_araddr,
    output logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic        s_axi_rvalid,
    output logic        s_axi_rready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp
);
    logic [1:0] last_bresp;   // response taken with the last write
    // idle bus from time zero; whole words only
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
    end
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        last_bresp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    // read holds rready until the answer
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : axi_host_model
`default_nettype wire

// file: scripted_pwm_ramp_engine_bench.sv
/* bench: scripts stored and run through the host model, then judged.
   assumes the checker and host model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`include "pwm_ramp_defs.svh"
module scripted_pwm_ramp_engine_bench;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0]  s_axi_wstrb;
    logic [2:0]  pwm_out, pwm_oe;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        cfg2_pwm_sel, irq_out;
    int          failures = 0;
    int          n_tests = 0;
    always #5 aclk = ~aclk;
    pwm_ramp_engine u_pwm_ramp_engine (.*);
    axi_host_model u_axi_host_model (.*);
    // ==================================
    // helpers
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        u_axi_host_model.rd(a, rd_data, rd_resp);
        check(rd_data, exp);
    endtask : rchk
    task store(input logic [1:0] ch, input logic [5:0] a, input logic [15:0] w);
        u_axi_host_model.wr(`OFS_WRITE, {6'h00, ch, 2'h0, a, w});
    endtask : store
    // bounded wait for the host interrupt
    task wait_irq(input int lim);
        int k;
        k = 0;
        while (irq_out !== 1'b1 && k < lim)
        begin
            @(posedge aclk);
            k++;
        end
        check({31'h0, irq_out}, 32'h1);
    endtask : wait_irq
    task conclude;
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    // ==================================
    // tests
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`OFS_STATUS, 32'h0);
        rchk(`OFS_DUTY, 32'h0);
        rchk(8'h14, 32'h0);
        check({30'h0, rd_resp}, 32'h2);
        check({29'h0, pwm_out}, 32'h0);
        u_axi_host_model.wr(8'h14, 32'h0);
        check({30'h0, u_axi_host_model.last_bresp}, 32'h2);
        $display("test reset done");
        u_axi_host_model.wr(`OFS_CTRL, 32'h1500);
        check({30'h0, u_axi_host_model.last_bresp}, 32'h0);
        rchk(`OFS_CTRL, 32'h1500);
        check({31'h0, cfg2_pwm_sel}, 32'h1);
        $display("test control done");
        store(2'h1, 6'h00, 16'h40FF);
        store(2'h1, 6'h01, 16'hC800);
        u_axi_host_model.wr(`OFS_CTRL, 32'h1502);
        wait_irq(30000);
        rchk(`OFS_DUTY, 32'hFF00);
        rchk(`OFS_IRQ, 32'h2);
        check({29'h0, pwm_oe}, 32'h0);
        u_axi_host_model.wr(`OFS_IRQ, 32'h2);
        rchk(`OFS_IRQ, 32'h0);
        $display("test script end done");
        store(2'h0, 6'h00, 16'h0181);
        store(2'h0, 6'h01, 16'hC000);
        u_axi_host_model.wr(`OFS_CTRL, 32'h1501);
        repeat (20000) @(posedge aclk);
        u_axi_host_model.wr(`OFS_CTRL, 32'h1510);
        rchk(`OFS_STATUS, 32'h1);
        wait_irq(70000);
        rchk(`OFS_DUTY, 32'hFF00);
        check({29'h0, pwm_oe}, 32'h1);
        rchk(`OFS_STATUS, 32'h0);
        check({29'h0, pwm_out}, 32'h0);
        $display("test ramp done");
        conclude();
    end
    // watchdog above the longest expected run
    initial
    begin
        #900000;
        failures++;
        conclude();
    end
endmodule : scripted_pwm_ramp_engine_bench
bind pwm_ramp_engine pwm_ramp_engine_sva u_sva (.*);
`default_nettype wire
